// [core/bdm_defines.vh]
`ifndef BDM_DEFINES_VH
`define BDM_DEFINES_VH
// Address layout
`define BDM_ADDR_W 12
`define BDM_BANK_W 4
`define BDM_BANK_LSB 8
`define BDM_ACC_SPLIT 8'h80
`define BDM_ACC_HIGH_BANK 4'hF
`define BDM_ACC_LOW_BANK 4'h0
// Special function windows
`define BDM_SFR14_LO 12'hE00
`define BDM_SFR14_HI 12'hE7F
`define BDM_SFR15_LO 12'hF80
// Core register offsets
`define BDM_PTR2_LOW 12'hFD9
`define BDM_PTR2_HIGH 12'hFDA
`define BDM_PTR2_PLUSW 12'hFDB
`define BDM_PTR2_PREINC 12'hFDC
`define BDM_PTR2_POSTDEC 12'hFDD
`define BDM_PTR2_POSTINC 12'hFDE
`define BDM_PTR2_PLAIN 12'hFDF
`define BDM_BANK_SEL 12'hFE0
`define BDM_PTR1_LOW 12'hFE1
`define BDM_PTR1_HIGH 12'hFE2
`define BDM_PTR1_PLUSW 12'hFE3
`define BDM_PTR1_PREINC 12'hFE4
`define BDM_PTR1_POSTDEC 12'hFE5
`define BDM_PTR1_POSTINC 12'hFE6
`define BDM_PTR1_PLAIN 12'hFE7
`define BDM_WORKING_ACCUMULATOR 12'hFE8
`define BDM_PTR0_LOW 12'hFE9
`define BDM_PTR0_HIGH 12'hFEA
`define BDM_PTR0_PLUSW 12'hFEB
`define BDM_PTR0_PREINC 12'hFEC
`define BDM_PTR0_POSTDEC 12'hFED
`define BDM_PTR0_POSTINC 12'hFEE
`define BDM_PTR0_PLAIN 12'hFEF
`define BDM_TBL_LATCH 12'hFF5
`define BDM_TBL_LOW 12'hFF6
`define BDM_TBL_HIGH 12'hFF7
`define BDM_TBL_UPPER 12'hFF8
`define BDM_PC_LOW 12'hFF9
`define BDM_PC_HIGH_STG 12'hFFA
`define BDM_PC_UPPER_STG 12'hFFB
// Widths and timing
`define BDM_PC_W 21
`define BDM_BANK_RST 4'h0
`define BDM_Q_PHASES 2'h3
`endif

// [core/bdm_core.v]
`timescale 1ns/1ps
`default_nettype none
`include "bdm_defines.vh"
module bdm_core #(
   parameter IMPL_BANKS = 16,
   parameter PM_BYTES = 4096
) (
   // Clock and reset
   input wire clk,
   input wire resetn,
   // Instruction issue from the core
   input wire op_valid,
   input wire [3:0] op_kind,
   input wire op_access,
   input wire [7:0] op_offset,
   input wire [11:0] op_src_addr,
   input wire [11:0] op_dst_addr,
   input wire [7:0] op_wdata,
   input wire op_write,
   input wire [20:0] op_target,
   input wire [7:0] op_accum,
   // Program memory byte port
   input wire [7:0] pm_rdata,
   // Results
   output reg [7:0] rd_data_q,
   output reg rd_valid_q,
   output reg [11:0] eff_addr_q,
   output reg busy_q,
   output reg flush_q,
   output reg [20:0] prog_counter_q,
   output reg [20:0] pm_addr_q,
   output reg [7:0] pm_wdata_q,
   output reg pm_we_q,
   output reg [3:0] bank_sel_q
);
   localparam K_NOP = 4'h0;
   localparam K_READ = 4'h1;
   localparam K_WRITE = 4'h2;
   localparam K_MOVE = 4'h3;
   localparam K_BRANCH = 4'h4;
   localparam K_ADDPC = 4'h5;
   localparam K_TBLRD = 4'h6;
   localparam K_TBLWR = 4'h7;
   localparam K_SETBANK = 4'h8;
   localparam K_INDIRECT = 4'h9;
   localparam S_RUN = 2'h0;
   localparam S_MOVE2 = 2'h1;
   localparam S_FLUSH = 2'h2;

   // Storage array is never reset
   reg [7:0] mem [0:4095];
   reg [11:0] ptr0_q, ptr1_q, ptr2_q;
   reg [7:0] tbl_latch_q, pc_hi_stg_q, pc_up_stg_q;
   reg [20:0] tbl_addr_q;
   reg [1:0] state_q;
   reg [11:0] move_dst_q;
   reg [7:0] move_data_q;
   reg [11:0] addr_d;
   reg [5:0] ind_code;
   reg [11:0] ptr_cur;
   reg [11:0] ind_addr;
   reg [1:0] ind_sel;
   reg [2:0] ind_mode;
   reg ind_hit;
   reg ind_loop;
   reg [5:0] loop_code;
   reg [11:0] tgt_addr;
   reg tgt_ok;

   // Direct address formation
   function [11:0] dir_addr;
      input acc;
      input [7:0] off;
      input [3:0] bank;
      begin
         if (!acc) begin
            if (off < `BDM_ACC_SPLIT)
               dir_addr = {`BDM_ACC_LOW_BANK, off};
            else
               dir_addr = {`BDM_ACC_HIGH_BANK, off};
         end else begin
            dir_addr = {bank, off};
         end
      end
   endfunction

   // Implemented storage or special location
   function is_impl;
      input [11:0] a;
      begin
         if (a >= `BDM_SFR14_LO && a <= `BDM_SFR14_HI)
            is_impl = 1'b1;
         else if (a >= `BDM_SFR15_LO)
            is_impl = 1'b1;
         else if (a[11:8] == 4'hE || a[11:8] == 4'hF)
            is_impl = 1'b0;
         else
            is_impl = ({28'h0, a[11:8]} < IMPL_BANKS);
      end
   endfunction

   // Pointer port decode: [5] hit, [4:3] pointer, [2:0] mode
   // Five ports per pointer, so the mode needs three bits
   function [5:0] ind_dec;
      input [11:0] a;
      reg [11:0] d;
      begin
         ind_dec = 6'h00;
         d = 12'h000;
         if (a >= `BDM_PTR2_PLUSW && a <= `BDM_PTR2_PLAIN) begin
            d = a - `BDM_PTR2_PLUSW;
            ind_dec = {1'b1, 2'h2, d[2:0]};
         end else if (a >= `BDM_PTR1_PLUSW && a <= `BDM_PTR1_PLAIN) begin
            d = a - `BDM_PTR1_PLUSW;
            ind_dec = {1'b1, 2'h1, d[2:0]};
         end else if (a >= `BDM_PTR0_PLUSW && a <= `BDM_PTR0_PLAIN) begin
            d = a - `BDM_PTR0_PLUSW;
            ind_dec = {1'b1, 2'h0, d[2:0]};
         end
      end
   endfunction

   // Read mux for a given address
   function [7:0] rd_at;
      input [11:0] a;
      begin
         case (a)
            `BDM_BANK_SEL: rd_at = {4'h0, bank_sel_q};
            `BDM_PTR0_LOW: rd_at = ptr0_q[7:0];
            `BDM_PTR0_HIGH: rd_at = {4'h0, ptr0_q[11:8]};
            `BDM_PTR1_LOW: rd_at = ptr1_q[7:0];
            `BDM_PTR1_HIGH: rd_at = {4'h0, ptr1_q[11:8]};
            `BDM_PTR2_LOW: rd_at = ptr2_q[7:0];
            `BDM_PTR2_HIGH: rd_at = {4'h0, ptr2_q[11:8]};
            `BDM_TBL_LATCH: rd_at = tbl_latch_q;
            `BDM_TBL_LOW: rd_at = tbl_addr_q[7:0];
            `BDM_TBL_HIGH: rd_at = tbl_addr_q[15:8];
            `BDM_TBL_UPPER: rd_at = {3'h0, tbl_addr_q[20:16]};
            `BDM_PC_LOW: rd_at = prog_counter_q[7:0];
            `BDM_PC_HIGH_STG: rd_at = pc_hi_stg_q;
            `BDM_PC_UPPER_STG: rd_at = pc_up_stg_q;
            default: rd_at = is_impl(a) ? mem[a] : 8'h00;
         endcase
      end
   endfunction

   // Effective address, pointer addressing resolved
   // Registers are read here directly, never inside a function, so the
   // sensitivity list sees every pointer change
   always @* begin
      addr_d = (op_kind == K_MOVE) ? op_src_addr : dir_addr(op_access, op_offset, bank_sel_q);
      ind_code = ind_dec(addr_d);
      ind_hit = ind_code[5];
      ind_sel = ind_code[4:3];
      ind_mode = ind_code[2:0];
      case (ind_sel)
         2'h0: ptr_cur = ptr0_q;
         2'h1: ptr_cur = ptr1_q;
         default: ptr_cur = ptr2_q;
      endcase
      ind_addr = 12'h000;
      if (ind_hit) begin
         case (ind_mode)
            3'h0: ind_addr = ptr_cur + {{4{op_accum[7]}}, op_accum};
            3'h1: ind_addr = ptr_cur + 12'h001;
            default: ind_addr = ptr_cur;
         endcase
      end
      // Pointer aimed at a pointer port: reads zero, writes dropped
      loop_code = ind_dec(ind_addr);
      ind_loop = ind_hit && loop_code[5];
      tgt_addr = ind_hit ? ind_addr : addr_d;
      tgt_ok = !ind_loop;
   end

   task do_write;
      input [11:0] a;
      input [7:0] v;
      begin
         case (a)
            `BDM_BANK_SEL: bank_sel_q <= v[3:0];
            `BDM_PTR0_LOW: ptr0_q[7:0] <= v;
            `BDM_PTR0_HIGH: ptr0_q[11:8] <= v[3:0];
            `BDM_PTR1_LOW: ptr1_q[7:0] <= v;
            `BDM_PTR1_HIGH: ptr1_q[11:8] <= v[3:0];
            `BDM_PTR2_LOW: ptr2_q[7:0] <= v;
            `BDM_PTR2_HIGH: ptr2_q[11:8] <= v[3:0];
            `BDM_TBL_LATCH: tbl_latch_q <= v;
            // Program memory address follows the pointer, so a read right
            // after a pointer write already sees the new byte
            `BDM_TBL_LOW: begin
               tbl_addr_q[7:0] <= v;
               pm_addr_q[7:0] <= v;
            end
            `BDM_TBL_HIGH: begin
               tbl_addr_q[15:8] <= v;
               pm_addr_q[15:8] <= v;
            end
            `BDM_TBL_UPPER: begin
               tbl_addr_q[20:16] <= v[4:0];
               pm_addr_q[20:16] <= v[4:0];
            end
            `BDM_PC_LOW: prog_counter_q <= {pc_up_stg_q[4:0], pc_hi_stg_q, v[7:1], 1'b0};
            `BDM_PC_HIGH_STG: pc_hi_stg_q <= v;
            `BDM_PC_UPPER_STG: pc_up_stg_q <= v;
            default: begin
               // Storage itself is written in the unreset process below
            end
         endcase
      end
   endtask

   // Storage writes kept out of reset so contents survive it
   always @(posedge clk) begin
      if (state_q == S_MOVE2) begin
         if (is_impl(move_dst_q))
            mem[move_dst_q] <= move_data_q;
      end else if (state_q == S_RUN && op_valid && op_kind == K_WRITE) begin
         if (tgt_ok && is_impl(tgt_addr))
            mem[tgt_addr] <= op_wdata;
      end
   end

   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         bank_sel_q <= `BDM_BANK_RST;
         ptr0_q <= 12'h000;
         ptr1_q <= 12'h000;
         ptr2_q <= 12'h000;
         tbl_latch_q <= 8'h00;
         tbl_addr_q <= 21'h000000;
         pc_hi_stg_q <= 8'h00;
         pc_up_stg_q <= 8'h00;
         prog_counter_q <= 21'h000000;
         state_q <= S_RUN;
         move_dst_q <= 12'h000;
         move_data_q <= 8'h00;
         rd_data_q <= 8'h00;
         rd_valid_q <= 1'b0;
         eff_addr_q <= 12'h000;
         busy_q <= 1'b0;
         flush_q <= 1'b0;
         pm_addr_q <= 21'h000000;
         pm_wdata_q <= 8'h00;
         pm_we_q <= 1'b0;
      end else begin
         rd_valid_q <= 1'b0;
         pm_we_q <= 1'b0;
         flush_q <= 1'b0;
         busy_q <= 1'b0;
         case (state_q)
            S_MOVE2: begin
               do_write(move_dst_q, move_data_q);
               state_q <= S_RUN;
            end
            S_FLUSH: begin
               state_q <= S_RUN;
            end
            default: begin
               if (op_valid) begin
                  prog_counter_q <= prog_counter_q + 21'h2;
                  eff_addr_q <= tgt_addr;
                  case (op_kind)
                     K_READ, K_INDIRECT: begin
                        rd_data_q <= tgt_ok ? rd_at(tgt_addr) : 8'h00;
                        rd_valid_q <= 1'b1;
                        if (addr_d == `BDM_PC_LOW) begin
                           pc_hi_stg_q <= prog_counter_q[15:8];
                           pc_up_stg_q <= {3'h0, prog_counter_q[20:16]};
                        end
                     end
                     K_WRITE: begin
                        if (tgt_ok)
                           do_write(tgt_addr, op_wdata);
                     end
                     K_MOVE: begin
                        // Second word carries the destination; one extra cycle
                        move_dst_q <= op_dst_addr;
                        move_data_q <= tgt_ok ? rd_at(tgt_addr) : 8'h00;
                        state_q <= S_MOVE2;
                        busy_q <= 1'b1;
                        prog_counter_q <= prog_counter_q + 21'h4;
                     end
                     K_BRANCH: begin
                        prog_counter_q <= {op_target[20:1], 1'b0};
                        flush_q <= 1'b1;
                        busy_q <= 1'b1;
                        state_q <= S_FLUSH;
                     end
                     K_ADDPC: begin
                        // Full-width add, so a table may cross a 256-byte page
                        prog_counter_q <= prog_counter_q + {13'h0000, op_accum};
                        flush_q <= 1'b1;
                        busy_q <= 1'b1;
                        state_q <= S_FLUSH;
                     end
                     K_TBLRD: begin
                        pm_addr_q <= tbl_addr_q;
                        tbl_latch_q <= pm_rdata;
                     end
                     K_TBLWR: begin
                        pm_addr_q <= tbl_addr_q;
                        pm_wdata_q <= tbl_latch_q;
                        pm_we_q <= 1'b1;
                     end
                     K_SETBANK: begin
                        bank_sel_q <= op_wdata[3:0];
                     end
                     default: begin
                     end
                  endcase
               end
            end
         endcase
      end
   end
   // Pointer auto-modify is left to the pointer owner; only addressing here
   wire unused_ok = ^{ind_mode[2], op_write, PM_BYTES[0]};
endmodule
`default_nettype wire

// [tb/bdm_pm_model.sv]
`timescale 1ns/1ps
`default_nettype none
module bdm_pm_model (
   // Program memory byte port
   input wire logic clk,
   input wire logic [20:0] pm_addr,
   input wire logic [7:0] pm_wdata,
   input wire logic pm_we,
   output logic [7:0] pm_rdata
);
   // Low byte decode only, short tables need no more
   logic [7:0] mem [0:255];
   initial begin
      for (int i = 0; i < 256; i++)
         mem[i] = 8'(i) ^ 8'h5A;
   end
   always @(posedge clk) begin
      if (pm_we)
         mem[pm_addr[7:0]] <= pm_wdata;
   end
   assign pm_rdata = mem[pm_addr[7:0]];
endmodule
`default_nettype wire

// [tb/bdm_core_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
module bdm_core_chk (
   // Watched ports
   input wire logic clk,
   input wire logic resetn,
   input wire logic op_valid,
   input wire logic [3:0] op_kind,
   input wire logic op_access,
   input wire logic [7:0] op_offset,
   input wire logic rd_valid_q,
   input wire logic [11:0] eff_addr_q,
   input wire logic busy_q,
   input wire logic flush_q,
   input wire logic [20:0] prog_counter_q,
   input wire logic pm_we_q,
   input wire logic [3:0] bank_sel_q
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   wire logic go = op_valid && !busy_q;
   wire logic rd_go = go && op_kind == 4'h1;
   // Pointer port offsets resolve through a pointer, not the window
   wire logic ind_port = (op_offset >= 8'hDB && op_offset <= 8'hDF) ||
      (op_offset >= 8'hE3 && op_offset <= 8'hE7) || (op_offset >= 8'hEB && op_offset <= 8'hEF);
   property p_acc_low;
      rd_go && !op_access && !op_offset[7] |=> eff_addr_q == {4'h0, $past(op_offset)};
   endproperty
   a_acc_low: assert property (p_acc_low) else $error("window low address wrong");
   property p_acc_high;
      rd_go && !op_access && op_offset[7] && !ind_port |=> eff_addr_q == {4'hF, $past(op_offset)};
   endproperty
   a_acc_high: assert property (p_acc_high) else $error("window high address wrong");
   property p_banked;
      rd_go && op_access |=> eff_addr_q == {$past(bank_sel_q), $past(op_offset)};
   endproperty
   a_banked: assert property (p_banked) else $error("banked address wrong");
   property p_rd_pulse;
      rd_go |=> rd_valid_q;
   endproperty
   a_rd_pulse: assert property (p_rd_pulse) else $error("read answer missing");
   property p_pc_step;
      rd_go |=> prog_counter_q == $past(prog_counter_q) + 21'h2;
   endproperty
   a_pc_step: assert property (p_pc_step) else $error("program counter step wrong");
   property p_branch;
      go && op_kind == 4'h4 |=> busy_q && flush_q ##1 !busy_q;
   endproperty
   a_branch: assert property (p_branch) else $error("branch not two cycles");
   property p_move;
      go && op_kind == 4'h3 |=> busy_q && !flush_q ##1 !busy_q;
   endproperty
   a_move: assert property (p_move) else $error("move not two cycles");
   property p_twrite;
      go && op_kind == 4'h7 |=> pm_we_q ##1 !pm_we_q;
   endproperty
   a_twrite: assert property (p_twrite) else $error("table write pulse wrong");
endmodule
bind bdm_core bdm_core_chk u_chk (.clk(clk), .resetn(resetn), .op_valid(op_valid), .op_kind(op_kind),
   .op_access(op_access), .op_offset(op_offset), .rd_valid_q(rd_valid_q), .eff_addr_q(eff_addr_q),
   .busy_q(busy_q), .flush_q(flush_q), .prog_counter_q(prog_counter_q), .pm_we_q(pm_we_q),
   .bank_sel_q(bank_sel_q));
`default_nettype wire

// [tb/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic op_valid = 1'b0;
   logic [3:0] op_kind = 4'h0;
   logic op_access = 1'b0;
   logic [7:0] op_offset = 8'h00;
   logic [11:0] op_src_addr = 12'h000;
   logic [11:0] op_dst_addr = 12'h000;
   logic [7:0] op_wdata = 8'h00;
   logic [20:0] op_target = 21'h000000;
   logic [7:0] op_accum = 8'h00;
   wire logic [7:0] pm_rdata;
   wire logic [7:0] rd_data_q;
   wire logic rd_valid_q;
   wire logic [11:0] eff_addr_q;
   wire logic busy_q;
   wire logic flush_q;
   wire logic [20:0] prog_counter_q;
   wire logic [20:0] pm_addr_q;
   wire logic [7:0] pm_wdata_q;
   wire logic pm_we_q;
   wire logic [3:0] bank_sel_q;
   int error_cnt = 0;
   int samples_checked = 0;
   always #12.5 clk = ~clk;
   bdm_core u_bdm_core (.clk(clk), .resetn(resetn), .op_valid(op_valid), .op_kind(op_kind),
      .op_access(op_access), .op_offset(op_offset), .op_src_addr(op_src_addr), .op_dst_addr(op_dst_addr),
      .op_wdata(op_wdata), .op_write(1'b0), .op_target(op_target), .op_accum(op_accum),
      .pm_rdata(pm_rdata), .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q), .eff_addr_q(eff_addr_q),
      .busy_q(busy_q), .flush_q(flush_q), .prog_counter_q(prog_counter_q), .pm_addr_q(pm_addr_q),
      .pm_wdata_q(pm_wdata_q), .pm_we_q(pm_we_q), .bank_sel_q(bank_sel_q));
   bdm_pm_model u_bdm_pm_model (.clk(clk), .pm_addr(pm_addr_q), .pm_wdata(pm_wdata_q), .pm_we(pm_we_q),
      .pm_rdata(pm_rdata));
   task automatic end_of_test;
      $display("checks %0d errors %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic op(input logic [3:0] k, input logic a, input logic [7:0] off, input logic [7:0] d);
      @(posedge clk);
      op_valid <= 1'b1;
      op_kind <= k;
      op_access <= a;
      op_offset <= off;
      op_wdata <= d;
      @(posedge clk);
      op_valid <= 1'b0;
      #1;
   endtask
   task automatic chk(input logic [20:0] got, input logic [20:0] exp);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
      end
   endtask
   task automatic rd(input logic a, input logic [7:0] off, input logic [7:0] exp);
      op(4'h1, a, off, 8'h00);
      chk({13'h0, rd_data_q}, {13'h0, exp});
   endtask
   // Watchdog, a hang ends the run as a mismatch
   initial begin
      #100000;
      error_cnt++;
      end_of_test;
   end
   initial begin
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      op(4'h2, 1'b0, 8'h10, 8'hA5);
      rd(1'b0, 8'h10, 8'hA5);
      op(4'h2, 1'b0, 8'hE0, 8'hFF);
      rd(1'b0, 8'hE0, 8'h0F);
      chk({17'h0, bank_sel_q}, 21'h00000F);
      op(4'h2, 1'b1, 8'h10, 8'h3C);
      rd(1'b1, 8'h10, 8'h00);
      op(4'h8, 1'b0, 8'h02, 8'h02);
      op(4'h2, 1'b1, 8'h33, 8'h22);
      rd(1'b1, 8'h33, 8'h22);
      op(4'h8, 1'b0, 8'h00, 8'h0E);
      rd(1'b1, 8'h90, 8'h00);
      op(4'h2, 1'b0, 8'hE9, 8'h33);
      op(4'h2, 1'b0, 8'hEA, 8'h02);
      rd(1'b0, 8'hEF, 8'h22);
      @(posedge clk);
      op_src_addr <= 12'h233;
      op_dst_addr <= 12'h044;
      op_target <= 21'h000100;
      op_accum <= 8'h06;
      op(4'h3, 1'b0, 8'h00, 8'h00);
      @(posedge clk);
      rd(1'b0, 8'h44, 8'h22);
      op(4'h4, 1'b0, 8'h00, 8'h00);
      chk({20'h0, flush_q}, 21'h000001);
      @(posedge clk);
      #1;
      chk(prog_counter_q, 21'h000100);
      op(4'h5, 1'b0, 8'h00, 8'h00);
      chk(prog_counter_q, 21'h000106);
      @(posedge clk);
      op(4'h2, 1'b0, 8'hF6, 8'h34);
      op(4'h2, 1'b0, 8'hF7, 8'h12);
      op(4'h2, 1'b0, 8'hF8, 8'h00);
      // Second table read covers a registered address path
      op(4'h6, 1'b0, 8'h00, 8'h00);
      op(4'h6, 1'b0, 8'h00, 8'h00);
      rd(1'b0, 8'hF5, 8'h6E);
      op(4'h2, 1'b0, 8'hF5, 8'h77);
      op(4'h7, 1'b0, 8'h00, 8'h00);
      chk(pm_addr_q, 21'h001234);
      op(4'h2, 1'b0, 8'hF5, 8'h00);
      op(4'h6, 1'b0, 8'h00, 8'h00);
      op(4'h6, 1'b0, 8'h00, 8'h00);
      rd(1'b0, 8'hF5, 8'h77);
      @(posedge clk);
      resetn <= 1'b0;
      @(posedge clk);
      resetn <= 1'b1;
      #1;
      chk({17'h0, bank_sel_q}, 21'h000000);
      rd(1'b0, 8'h10, 8'hA5);
      end_of_test;
   end
endmodule
`default_nettype wire
